// *** include/bus_hold_pkg.sv ***
// Summary of operation
// - Idle bus: next cycle after request, float address, data and all strobes.
// - In that same cycle the low grant output is asserted.
// - Halt when granted, or with run-on mode halt only at an external access.
// - A request during an external access waits until the cycle after it ends.
// - Grant may fall between two external accesses of one instruction.
// - Request released: drop grant, drive bus again, resume where stopped.
// - Requests are honoured even in boot and during core reset.
// - Grant-hang goes low while ready and needing an external access but the bus is granted away.
// - On release drop grant and grant-hang, then do the pending external access.
// - Emulator takeover swaps in emulator reset, request and grant pins.
// - During emulator takeover the normal grant pin is three-stated.
// - Under emulation ignore target reset and request when stepping or halted.
package bus_hold_pkg;

  localparam logic [1:0] SYNC_RESET_VALUE = 2'h3;
  localparam logic REQ_IDLE = 1'h1;
  localparam logic GRANT_IDLE = 1'h1;

  // Gray order along idle -> waiting -> granted
  typedef enum logic [1:0] {
    ARB_IDLE = 2'h0,
    ARB_WAIT = 2'h1,
    ARB_GRANTED = 2'h3
  } arb_state_type;

  typedef struct packed {
    logic grant_n;
    logic grant_oe;
    logic emu_grant_n;
    logic grant_hang_n;
    logic bus_oe;
    logic halt;
  } hold_out_type;

endpackage

// *** rtl/external_bus_hold_grant.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_bus_hold_grant
  import bus_hold_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // Normal request and reset pins
  input wire logic HOLD_REQUEST_N_IN,
  input wire logic TARGET_RESET_N_IN,
  // Emulator pins
  input wire logic EMULATOR_TAKEOVER_IN,
  input wire logic EMU_HOLD_REQUEST_N_IN,
  input wire logic EMU_RESET_N_IN,
  input wire logic EMU_IGNORE_TARGET_IN,
  // Core status
  input wire logic EXT_ACCESS_BUSY_IN,
  input wire logic EXT_ACCESS_NEEDED_IN,
  input wire logic CORE_READY_IN,
  input wire logic RUN_ON_MODE_IN,
  // Grant outputs
  output logic HOLD_GRANT_N_OUT,
  output logic HOLD_GRANT_OE_OUT,
  output logic EMU_HOLD_GRANT_N_OUT,
  output logic GRANT_HANG_N_OUT,
  // Bus and core control
  output logic BUS_DRIVE_OE_OUT,
  output logic CORE_HALT_OUT,
  output logic CORE_RESET_N_OUT
);

  // ----------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] req_sync_q;
  logic [1:0] ereq_sync_q;
  logic [1:0] emu_sync_q;
  logic [1:0] ign_sync_q;
  logic [1:0] trst_sync_q;
  logic [1:0] erst_sync_q;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Only bit 1 of each pair is read by the logic
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      req_sync_q <= SYNC_RESET_VALUE;
      ereq_sync_q <= SYNC_RESET_VALUE;
      emu_sync_q <= 2'h0;
      ign_sync_q <= 2'h0;
      trst_sync_q <= SYNC_RESET_VALUE;
      erst_sync_q <= SYNC_RESET_VALUE;
    end else begin
      req_sync_q <= {req_sync_q[0], HOLD_REQUEST_N_IN};
      ereq_sync_q <= {ereq_sync_q[0], EMU_HOLD_REQUEST_N_IN};
      emu_sync_q <= {emu_sync_q[0], EMULATOR_TAKEOVER_IN};
      ign_sync_q <= {ign_sync_q[0], EMU_IGNORE_TARGET_IN};
      trst_sync_q <= {trst_sync_q[0], TARGET_RESET_N_IN};
      erst_sync_q <= {erst_sync_q[0], EMU_RESET_N_IN};
    end
  end

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  logic emu;
  logic req_active;
  logic core_rst_n;

  assign emu = emu_sync_q[1];
  // Target request and reset are masked while the emulator steps or halts
  assign req_active = emu ? (!ereq_sync_q[1] || (!ign_sync_q[1] && !req_sync_q[1]))
                          : !req_sync_q[1];
  assign core_rst_n = emu ? (erst_sync_q[1] && (ign_sync_q[1] || trst_sync_q[1]))
                          : trst_sync_q[1];

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  // The arbiter does not depend on core reset, so requests work during it
  arb_state_type state_q;
  arb_state_type state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ARB_IDLE: begin
        if (req_active && EXT_ACCESS_BUSY_IN) begin
          state_d = ARB_WAIT;
        end else if (req_active) begin
          state_d = ARB_GRANTED;
        end
      end
      ARB_WAIT: begin
        if (!req_active) begin
          state_d = ARB_IDLE;
        end else if (!EXT_ACCESS_BUSY_IN) begin
          state_d = ARB_GRANTED;
        end
      end
      ARB_GRANTED: begin
        if (!req_active) begin
          state_d = ARB_IDLE;
        end
      end
      default: begin
        state_d = ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ARB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  hold_out_type out_q;
  hold_out_type out_d;
  logic granted_d;
  logic core_rst_q;

  always_comb begin
    granted_d = (state_d == ARB_GRANTED);
    out_d.grant_n = emu ? GRANT_IDLE : !granted_d;
    out_d.grant_oe = !emu;
    out_d.emu_grant_n = emu ? !granted_d : GRANT_IDLE;
    out_d.bus_oe = !granted_d;
    // Run-on mode halts only once an external access is wanted
    out_d.halt = granted_d && (!RUN_ON_MODE_IN || EXT_ACCESS_NEEDED_IN);
    out_d.grant_hang_n = !(granted_d && CORE_READY_IN && EXT_ACCESS_NEEDED_IN);
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '{grant_n: GRANT_IDLE, grant_oe: 1'h1, emu_grant_n: GRANT_IDLE,
                 grant_hang_n: 1'h1, bus_oe: 1'h1, halt: 1'h0};
      core_rst_q <= 1'h0;
    end else begin
      out_q <= out_d;
      core_rst_q <= core_rst_n;
    end
  end

  assign HOLD_GRANT_N_OUT = out_q.grant_n;
  assign HOLD_GRANT_OE_OUT = out_q.grant_oe;
  assign EMU_HOLD_GRANT_N_OUT = out_q.emu_grant_n;
  assign GRANT_HANG_N_OUT = out_q.grant_hang_n;
  assign BUS_DRIVE_OE_OUT = out_q.bus_oe;
  assign CORE_HALT_OUT = out_q.halt;
  assign CORE_RESET_N_OUT = core_rst_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_sync_latency: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (!emu && $fell(req_sync_q[1]) && state_q == ARB_IDLE && !EXT_ACCESS_BUSY_IN)
    |=> !HOLD_GRANT_N_OUT) else $error("grant late after request");
  a_float_grant: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (BUS_DRIVE_OE_OUT == (state_q != ARB_GRANTED)))
    else $error("bus drive not tied to grant");
  a_grant_pair: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (!emu && $past(!emu)) |-> (HOLD_GRANT_N_OUT == BUS_DRIVE_OE_OUT))
    else $error("grant and float differ");
  a_busy_defer: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_q == ARB_IDLE && req_active && EXT_ACCESS_BUSY_IN) |=> BUS_DRIVE_OE_OUT)
    else $error("bus taken during access");
  a_release_fast: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_q == ARB_GRANTED && !req_active) |=> (BUS_DRIVE_OE_OUT && GRANT_HANG_N_OUT))
    else $error("release late");
  a_halt_mode: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_d == ARB_GRANTED && !RUN_ON_MODE_IN) |=> CORE_HALT_OUT)
    else $error("no halt when granted");
  a_hang_cause: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    !GRANT_HANG_N_OUT |-> !BUS_DRIVE_OE_OUT)
    else $error("hang without grant");
  a_emu_float: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    ##1 $past(emu) |-> !HOLD_GRANT_OE_OUT)
    else $error("grant driven in emulation");
  c_grant: cover property (@(posedge CLK_IN) disable iff (!rst_n) !HOLD_GRANT_N_OUT);
  c_wait: cover property (@(posedge CLK_IN) disable iff (!rst_n)
    state_q == ARB_WAIT ##1 state_q == ARB_GRANTED);
  c_emu_grant: cover property (@(posedge CLK_IN) disable iff (!rst_n)
    !EMU_HOLD_GRANT_N_OUT);
  c_run_on: cover property (@(posedge CLK_IN) disable iff (!rst_n)
    !HOLD_GRANT_N_OUT && RUN_ON_MODE_IN && !CORE_HALT_OUT);
  c_reset_grant: cover property (@(posedge CLK_IN) disable iff (!rst_n)
    !HOLD_GRANT_N_OUT && !CORE_RESET_N_OUT);

  // ----------------------------------------
  // Arbitration timing checks
  // ----------------------------------------
  // Idle bus is floated on the very next edge
  a_idle_grant: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_q == ARB_IDLE && req_active && !EXT_ACCESS_BUSY_IN) |=> !BUS_DRIVE_OE_OUT)
    else $error("idle bus not floated");

  // Normal grant pin follows the arbiter outside emulation
  a_normal_grant: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (!emu && state_d == ARB_GRANTED) |=> !HOLD_GRANT_N_OUT)
    else $error("normal grant missing");

  // A busy access keeps the bus driven
  a_busy_hold: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_q == ARB_WAIT && req_active && EXT_ACCESS_BUSY_IN) |=> BUS_DRIVE_OE_OUT)
    else $error("bus taken while busy");

  // Waiting state never floats the bus
  a_wait_float: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_q == ARB_WAIT) |-> BUS_DRIVE_OE_OUT)
    else $error("bus floated while waiting");

  // Grant follows the cycle after the access ends
  a_wait_grant: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_q == ARB_WAIT && req_active && !EXT_ACCESS_BUSY_IN) |=> !BUS_DRIVE_OE_OUT)
    else $error("grant late after access");

  // Grant stands while the request stands
  a_grant_stand: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_q == ARB_GRANTED && req_active) |=> !BUS_DRIVE_OE_OUT)
    else $error("grant dropped early");

  // Core runs again once the bus is back
  a_halt_free: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_d != ARB_GRANTED) |=> !CORE_HALT_OUT)
    else $error("halt without grant");

  // Core reset must not block the hand-over
  a_reset_arb: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (!core_rst_n && state_q == ARB_IDLE && req_active && !EXT_ACCESS_BUSY_IN)
    |=> !BUS_DRIVE_OE_OUT) else $error("no grant in core reset");

  // ----------------------------------------
  // Emulator routing checks
  // ----------------------------------------
  // Grant moves to the emulator pin
  a_emu_grant: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (emu && state_d == ARB_GRANTED) |=> (!EMU_HOLD_GRANT_N_OUT && HOLD_GRANT_N_OUT))
    else $error("emulator grant missing");

  // Emulator grant stays idle outside emulation
  a_emu_idle: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    !emu |=> EMU_HOLD_GRANT_N_OUT)
    else $error("emulator grant outside emulation");

  // Normal grant pin is driven outside emulation
  a_grant_oe: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    !emu |=> HOLD_GRANT_OE_OUT)
    else $error("grant pin floated");

  // Floated grant pin also carries its idle level
  a_normal_idle: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    emu |=> HOLD_GRANT_N_OUT)
    else $error("normal grant in emulation");

  // Core reset comes from the target pin outside emulation
  a_reset_route: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    !emu |=> (CORE_RESET_N_OUT == $past(trst_sync_q[1])))
    else $error("core reset source wrong");

  // Target reset is masked while the emulator steps or halts
  a_reset_ignore: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (emu && ign_sync_q[1] && erst_sync_q[1]) |=> CORE_RESET_N_OUT)
    else $error("target reset not ignored");

  // Target request is masked the same way
  a_req_ignore: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (emu && ign_sync_q[1] && ereq_sync_q[1]) |-> !req_active)
    else $error("target request not ignored");

  // ----------------------------------------
  // Core status checks
  // ----------------------------------------
  // Run-on mode keeps going until an external access is wanted
  a_run_on: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (RUN_ON_MODE_IN && !EXT_ACCESS_NEEDED_IN) |=> !CORE_HALT_OUT)
    else $error("run-on halted early");

  // Stall on a granted bus is flagged
  a_hang_set: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_d == ARB_GRANTED && CORE_READY_IN && EXT_ACCESS_NEEDED_IN)
    |=> !GRANT_HANG_N_OUT) else $error("hang not flagged");

  // Release clears grant and hang together
  a_hang_release: assert property (@(posedge CLK_IN) disable iff (!rst_n)
    (state_d != ARB_GRANTED)
    |=> (GRANT_HANG_N_OUT && HOLD_GRANT_N_OUT && EMU_HOLD_GRANT_N_OUT))
    else $error("release incomplete");

endmodule
`default_nettype wire

// *** testbench/bus_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input wire logic clk_in,
  input wire logic want_in,
  input wire logic grant_n_in,
  output logic req_n_out = 1'h1,
  output logic drive_bus_out
);
  // Request held low for as long as the master wants the bus
  always @(posedge clk_in) req_n_out <= #1 ~want_in;
  // Never drive the bus before the grant is seen
  assign drive_bus_out = ~req_n_out & ~grant_n_in;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bus_hold_pkg::*;
  logic clk = 1'h0, rst_b = 1'h0, want = 1'h0, tr_n = 1'h1, take = 1'h0;
  logic ereq_n = 1'h1, erst_n = 1'h1, ign = 1'h0;
  logic busy = 1'h0, need = 1'h0, ready = 1'h0, run_on = 1'h0;
  logic req_n, use_bus, g_n, g_oe, eg_n, hang_n, bus_oe, halt, crst_n;
  int err_count = 0;
  int cmp_count = 0;
  // Rows: run_on, need, ready, halt, hang_n
  logic [4:0] rows [5] = '{5'h07, 5'h0E, 5'h15, 5'h1E, 5'h1B};
  always #2.5 clk = ~clk;
  bus_master_model u_master (.clk_in(clk), .want_in(want), .grant_n_in(g_n),
    .req_n_out(req_n), .drive_bus_out(use_bus));
  external_bus_hold_grant u_dut (.CLK_IN(clk), .RST_B_IN(rst_b),
    .HOLD_REQUEST_N_IN(req_n), .TARGET_RESET_N_IN(tr_n),
    .EMULATOR_TAKEOVER_IN(take), .EMU_HOLD_REQUEST_N_IN(ereq_n),
    .EMU_RESET_N_IN(erst_n), .EMU_IGNORE_TARGET_IN(ign),
    .EXT_ACCESS_BUSY_IN(busy), .EXT_ACCESS_NEEDED_IN(need),
    .CORE_READY_IN(ready), .RUN_ON_MODE_IN(run_on),
    .HOLD_GRANT_N_OUT(g_n), .HOLD_GRANT_OE_OUT(g_oe),
    .EMU_HOLD_GRANT_N_OUT(eg_n), .GRANT_HANG_N_OUT(hang_n),
    .BUS_DRIVE_OE_OUT(bus_oe), .CORE_HALT_OUT(halt), .CORE_RESET_N_OUT(crst_n));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a grant pin to fall
  task automatic wait_low(input bit emu);
    int i = 0;
    while (((emu ? eg_n : g_n) !== 1'h0) && i < 12) begin
      cyc(1);
      i++;
    end
    if (i == 12) begin
      err_count++;
      $display("FAIL grant expected 0 seen 1");
      stop_test();
    end
  endtask
  initial begin
    cyc(8);
    chk("grant", 1'h1, g_n);
    chk("bus drive", 1'h1, bus_oe);
    chk("core reset", 1'h0, crst_n);
    rst_b = 1'h1;
    cyc(6);
    foreach (rows[r]) begin
      {run_on, need, ready} = rows[r][4:2];
      want = 1'h1;
      wait_low(0);
      chk("bus drive", 1'h0, bus_oe);
      chk("halt", rows[r][1], halt);
      chk("hang", rows[r][0], hang_n);
      chk("master", 1'h1, use_bus);
      want = 1'h0;
      cyc(5);
      chk("grant", 1'h1, g_n);
      chk("bus drive", 1'h1, bus_oe);
      chk("halt", 1'h0, halt);
      chk("hang", 1'h1, hang_n);
      $display("row %0d done", r);
    end
    busy = 1'h1;
    want = 1'h1;
    cyc(8);
    chk("grant busy", 1'h1, g_n);
    busy = 1'h0;
    wait_low(0);
    chk("bus drive", 1'h0, bus_oe);
    want = 1'h0;
    tr_n = 1'h0;
    cyc(5);
    want = 1'h1;
    wait_low(0);
    chk("core reset", 1'h0, crst_n);
    want = 1'h0;
    tr_n = 1'h1;
    take = 1'h1;
    cyc(5);
    chk("grant oe", 1'h0, g_oe);
    ereq_n = 1'h0;
    wait_low(1);
    ereq_n = 1'h1;
    erst_n = 1'h0;
    cyc(5);
    chk("emu grant", 1'h1, eg_n);
    chk("core reset", 1'h0, crst_n);
    erst_n = 1'h1;
    ign = 1'h1;
    want = 1'h1;
    tr_n = 1'h0;
    cyc(8);
    chk("emu grant", 1'h1, eg_n);
    chk("core reset", 1'h1, crst_n);
    $display("awkward cases done");
    stop_test();
  end
endmodule
`default_nettype wire
